// File: hdl/fsp_pkg.sv
/*
 Constants and types shared by the flash self-program controller, the
 core-side command port and the link interface between them.
 Assumes one 50 MHz core clock shared by both ends.
*/
package fsp_pkg;

    // Table pointer and byte geometry
    localparam int PTR_W       = 22;
    localparam int PTR_LOW_W   = 21;
    localparam int BYTE_W      = 8;
    localparam int HOLD_N      = 8;
    localparam int HOLD_SEL_W  = 3;
    localparam int ROW_SEL_LSB = 6;
    localparam int ROW_BYTES   = 64;

    localparam logic [7:0] KEY_FIRST   = 8'h55;
    localparam logic [7:0] KEY_SECOND  = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    // nvm_control bit positions
    localparam int CTL_PGM_SEL = 7;
    localparam int CTL_CFG_SEL = 6;
    localparam int CTL_ERASE   = 4;
    localparam int CTL_WALLOW  = 2;
    localparam int CTL_START   = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Long write timing
    localparam int WRITE_TIME_US = 2000;
    localparam int CLK_FREQ_MHZ  = 50;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_FREQ_MHZ;

    // Avalon register word indices (byte address = 4 * index)
    localparam logic [2:0] REG_COMMAND = 3'h0;
    localparam logic [2:0] REG_POINTER = 3'h1;
    localparam logic [2:0] REG_STATUS  = 3'h2;
    localparam logic [2:0] REG_CONTROL = 3'h3;
    localparam logic [2:0] REG_INT     = 3'h4;

    // Command and status fields
    localparam int CMD_OP_LSB     = 0;
    localparam int CMD_MODE_LSB   = 4;
    localparam int CMD_DATA_LSB   = 8;
    localparam int STAT_BUSY      = 0;
    localparam int STAT_HOLD      = 1;
    localparam int STAT_LATCH_LSB = 8;
    localparam int INT_ALLOW      = 0;

    typedef enum logic [2:0]
    {
        OP_IDLE      = 3'b000,
        OP_SET_PTR   = 3'b001,
        OP_TBL_READ  = 3'b010,
        OP_TBL_WRITE = 3'b011,
        OP_CONTROL   = 3'b100,
        OP_UNLOCK    = 3'b101
    } fsp_op_type;

    typedef enum logic [1:0]
    {
        PTR_KEEP     = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC  = 2'b11
    } fsp_ptr_mode_type;

    typedef enum logic [1:0]
    {
        KEY_NONE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } fsp_key_type;

    typedef enum logic
    {
        ST_READY      = 1'b0,
        ST_LONG_WRITE = 1'b1
    } fsp_state_type;

endpackage

// File: hdl/fsp_link_if.sv
/*
 Link between the core-side command port and the flash controller.
 Assumes both ends run on the same core clock; ops are one-cycle pulses.
*/
interface fsp_link_if;
    import fsp_pkg::*;

    logic                   op_valid;
    fsp_op_type             op_code;
    fsp_ptr_mode_type       op_mode;
    logic [BYTE_W-1:0]      op_data;
    logic [PTR_W-1:0]       op_ptr;
    logic                   stall;
    logic [PTR_W-1:0]       table_pointer;
    logic [BYTE_W-1:0]      table_byte_latch;
    logic [BYTE_W-1:0]      nvm_control;

    modport dev
    (
        input  op_valid,
        input  op_code,
        input  op_mode,
        input  op_data,
        input  op_ptr,
        output stall,
        output table_pointer,
        output table_byte_latch,
        output nvm_control
    );

    modport core
    (
        output op_valid,
        output op_code,
        output op_mode,
        output op_data,
        output op_ptr,
        input  stall,
        input  table_pointer,
        input  table_byte_latch,
        input  nvm_control
    );

endinterface

// File: hdl/fsp_flash_ctrl.sv
/*
 Flash self-program controller: table pointer, table latch, eight holding
 registers, unlock key, timed row erase and block program, fetch port.
 Assumes ops arrive only while stall is low, one per cycle at most.
*/
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
module fsp_flash_ctrl
    import fsp_pkg::*;
#(
    parameter int FLASH_AW       = 12,
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    fsp_link_if.dev                  link,
    input  wire logic [FLASH_AW-1:0] fetch_addr,
    output logic      [BYTE_W-1:0]   fetch_data
);

    localparam int CNT_W = $clog2(WRITE_CYCLES_P + 1);

    logic [BYTE_W-1:0]   flash_mem [2**FLASH_AW];
    logic [BYTE_W-1:0]   hold      [HOLD_N];
    logic [PTR_W-1:0]    table_pointer;
    logic [BYTE_W-1:0]   table_byte_latch;
    logic [BYTE_W-1:0]   nvm_control;
    logic                stall;
    fsp_state_type       state;
    fsp_key_type         key;
    logic [CNT_W-1:0]    timer;
    logic                erase_job;
    logic [PTR_W-1:0]    job_ptr;
    logic                take;
    logic                start_req;
    logic                start_go;
    logic                finish;
    logic [PTR_W-1:0]    acc_ptr;

    // Step inside the low 21 bits, config space bit kept
    function automatic logic [PTR_W-1:0] ptr_step
    (
        input logic [PTR_W-1:0] ptr,
        input logic             down
    );
        logic [PTR_LOW_W-1:0] low;
        low = down ? ptr[PTR_LOW_W-1:0] - 1'b1
                   : ptr[PTR_LOW_W-1:0] + 1'b1;
        return {ptr[PTR_W-1], low};
    endfunction

    assign take      = ce && link.op_valid && (state == ST_READY);
    assign start_req = take && (link.op_code == OP_CONTROL)
                       && link.op_data[CTL_START];
    assign start_go  = start_req && (key == KEY_ARMED)
                       && link.op_data[CTL_WALLOW]
                       && link.op_data[CTL_PGM_SEL]
                       && !link.op_data[CTL_CFG_SEL];
    assign finish    = ce && (state == ST_LONG_WRITE) && (timer == '0);
    assign acc_ptr   = (link.op_mode == PTR_PRE_INC)
                       ? ptr_step(table_pointer, 1'b0) : table_pointer;

    assign link.stall            = stall;
    assign link.table_pointer    = table_pointer;
    assign link.table_byte_latch = table_byte_latch;
    assign link.nvm_control      = nvm_control;

    // Table pointer
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            table_pointer <= '0;
        else if (take)
        begin
            unique case (link.op_code)
                OP_SET_PTR:
                    table_pointer <= link.op_ptr;
                OP_TBL_READ, OP_TBL_WRITE:
                begin
                    unique case (link.op_mode)
                        PTR_POST_INC, PTR_PRE_INC:
                            table_pointer <=
                                ptr_step(table_pointer, 1'b0);
                        PTR_POST_DEC:
                            table_pointer <= ptr_step(table_pointer, 1'b1);
                        PTR_KEEP:
                            table_pointer <= table_pointer;
                    endcase
                end
                default:
                    table_pointer <= table_pointer;
            endcase
        end
    end

    // Table latch
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            table_byte_latch <= LATCH_RESET;
        else if (take && link.op_code == OP_TBL_READ)
            table_byte_latch <= acc_ptr[PTR_W-1] ? LATCH_RESET
                : flash_mem[acc_ptr[FLASH_AW-1:0]];
        else if (take && link.op_code == OP_TBL_WRITE)
            table_byte_latch <= link.op_data;
    end

    // Holding registers, untouched by the long write
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < HOLD_N; i++)
                hold[i] <= ERASED_BYTE;
        end
        else if (take && link.op_code == OP_TBL_WRITE)
            hold[acc_ptr[HOLD_SEL_W-1:0]] <= link.op_data;
    end

    // Unlock key
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            key <= KEY_NONE;
        else if (take && link.op_code == OP_UNLOCK)
        begin
            if (link.op_data == KEY_FIRST)
                key <= KEY_HALF;
            else if (key == KEY_HALF && link.op_data == KEY_SECOND)
                key <= KEY_ARMED;
            else
                key <= KEY_NONE;
        end
        else if (start_req)
            key <= KEY_NONE;
    end

    // Control register; start set only through the key
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            nvm_control <= CTL_RESET;
        else if (take && link.op_code == OP_CONTROL)
        begin
            nvm_control             <= link.op_data;
            nvm_control[CTL_START]  <= start_go;
        end
        else if (finish)
            nvm_control[CTL_START] <= 1'b0;
    end

    // Long write sequencer
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state     <= ST_READY;
            stall     <= 1'b0;
            timer     <= '0;
            erase_job <= 1'b0;
            job_ptr   <= '0;
        end
        else if (ce)
        begin
            unique case (state)
                ST_READY:
                    if (start_go)
                    begin
                        state     <= ST_LONG_WRITE;
                        stall     <= 1'b1;
                        timer     <= CNT_W'(WRITE_CYCLES_P - 1);
                        erase_job <= link.op_data[CTL_ERASE];
                        job_ptr   <= table_pointer;
                    end
                ST_LONG_WRITE:
                    if (timer == '0)
                    begin
                        state <= ST_READY;
                        stall <= 1'b0;
                    end
                    else
                        timer <= timer - 1'b1;
            endcase
        end
    end

    // Array changes only when the timer expires
    always_ff @(posedge core_clk)
    begin
        if (finish && !job_ptr[PTR_W-1])
        begin
            if (erase_job)
            begin
                for (int i = 0; i < ROW_BYTES; i++)
                    flash_mem[{job_ptr[FLASH_AW-1:ROW_SEL_LSB],
                               ROW_SEL_LSB'(i)}] <= ERASED_BYTE;
            end
            else
            begin
                for (int i = 0; i < HOLD_N; i++)
                    flash_mem[{job_ptr[FLASH_AW-1:HOLD_SEL_W],
                               HOLD_SEL_W'(i)}] <= hold[i];
            end
        end
    end

    // Instruction fetch port
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            fetch_data <= LATCH_RESET;
        else if (ce)
            fetch_data <= flash_mem[fetch_addr];
    end

endmodule

// File: hdl/fsp_core_port.sv
/*
 Core-side command port: Avalon-MM slave registers that issue table,
 control and key operations over the link and report its state.
 Assumes an Avalon master holding each request until waitrequest is low.
*/
module fsp_core_port
    import fsp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             global_interrupt_allow,
    fsp_link_if.core         link
);

    logic                op_valid;
    fsp_op_type          op_code;
    fsp_ptr_mode_type    op_mode;
    logic [BYTE_W-1:0]   op_data;
    logic [PTR_W-1:0]    op_ptr;
    logic [PTR_W-1:0]    ptr_stage;
    logic                allow_sw;
    logic                irq_hold;
    logic                stall_d;
    logic                cmd_write;
    logic                can_go;
    logic                accept;
    logic [31:0]         next_readdata;

    assign cmd_write = avs_write && (avs_address == REG_COMMAND);
    assign can_go    = !cmd_write || (!op_valid && !link.stall);
    assign accept    = ce && (avs_read || avs_write) && !avs_waitrequest;

    assign link.op_valid = op_valid;
    assign link.op_code  = op_code;
    assign link.op_mode  = op_mode;
    assign link.op_data  = op_data;
    assign link.op_ptr   = op_ptr;

    always_comb
    begin
        next_readdata = '0;
        unique case (avs_address)
            REG_POINTER:
                next_readdata[PTR_W-1:0] = link.table_pointer;
            REG_STATUS:
            begin
                next_readdata[STAT_BUSY] = link.stall | op_valid;
                next_readdata[STAT_HOLD] = irq_hold;
                next_readdata[STAT_LATCH_LSB +: BYTE_W] =
                    link.table_byte_latch;
            end
            REG_CONTROL:
                next_readdata[BYTE_W-1:0] = link.nvm_control;
            REG_INT:
                next_readdata[INT_ALLOW] = allow_sw;
            default:
                next_readdata = '0;
        endcase
    end

    // Waitrequest drops for one cycle once the request can be served
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end
        else if (ce)
        begin
            if (!avs_waitrequest)
                avs_waitrequest <= 1'b1;
            else if ((avs_read || avs_write) && can_go)
            begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? next_readdata : '0;
            end
        end
    end

    // One-cycle operation pulse per accepted command write
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            op_valid <= 1'b0;
            op_code  <= OP_IDLE;
            op_mode  <= PTR_KEEP;
            op_data  <= '0;
            op_ptr   <= '0;
        end
        else if (ce)
        begin
            op_valid <= accept && cmd_write;
            if (accept && cmd_write)
            begin
                op_code <= fsp_op_type'(avs_writedata[CMD_OP_LSB +: 3]);
                op_mode <= fsp_ptr_mode_type'(
                           avs_writedata[CMD_MODE_LSB +: 2]);
                op_data <= avs_writedata[CMD_DATA_LSB +: BYTE_W];
                op_ptr  <= ptr_stage;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ptr_stage <= '0;
        else if (accept && avs_write && avs_address == REG_POINTER)
            ptr_stage <= avs_writedata[PTR_W-1:0];
    end

    // Interrupts masked from the first key write to the long write end or a control write with start clear
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            allow_sw               <= 1'b0;
            irq_hold               <= 1'b0;
            stall_d                <= 1'b0;
            global_interrupt_allow <= 1'b0;
        end
        else if (ce)
        begin
            stall_d <= link.stall;
            if (accept && avs_write && avs_address == REG_INT)
                allow_sw <= avs_writedata[INT_ALLOW];
            if (op_valid && op_code == OP_UNLOCK)
                irq_hold <= 1'b1;
            else if ((stall_d && !link.stall) || (op_valid
                     && op_code == OP_CONTROL && !op_data[CTL_START]))
                irq_hold <= 1'b0;
            global_interrupt_allow <= allow_sw && !irq_hold;
        end
    end

endmodule

// File: dv/fsp_asserts.sv
/*
 Concurrent checks on the link between core port and flash controller.
 Assumes one core clock and a synchronous active-low reset.
*/
module fsp_asserts
    import fsp_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              op_valid,
    input fsp_op_type             op_code,
    input fsp_ptr_mode_type       op_mode,
    input wire logic [BYTE_W-1:0] op_data,
    input wire logic              stall,
    input wire logic [PTR_W-1:0]  table_pointer,
    input wire logic [BYTE_W-1:0] table_byte_latch,
    input wire logic [BYTE_W-1:0] nvm_control
);
    fsp_key_type key;
    int          stall_cnt;
    logic        take;
    logic        start_ok;

    assign take = op_valid && !stall;
    assign start_ok = take && op_code == OP_CONTROL && op_data[CTL_START]
        && op_data[CTL_WALLOW] && op_data[CTL_PGM_SEL]
        && !op_data[CTL_CFG_SEL];

    // Key progress as seen on the link
    always_ff @(posedge core_clk)
        if (!resetn)
            key <= KEY_NONE;
        else if (take && op_code == OP_UNLOCK)
            key <= (op_data == KEY_FIRST) ? KEY_HALF :
                   (op_data == KEY_SECOND && key == KEY_HALF) ? KEY_ARMED :
                   KEY_NONE;
        else if (take && op_code == OP_CONTROL && op_data[CTL_START])
            key <= KEY_NONE;

    always_ff @(posedge core_clk)
        if (!resetn || !stall)
            stall_cnt <= 0;
        else
            stall_cnt <= stall_cnt + 1;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_stall_length:
        assert property ($fell(stall) |-> stall_cnt == WRITE_CYCLES_P)
        else $error("long write length wrong");
    a_start_gate:
        assert property ($rose(stall) |-> $past(start_ok))
        else $error("long write without valid start");
    a_key_order:
        assert property ($rose(stall) |-> $past(key) == KEY_ARMED)
        else $error("long write without unlock key");
    a_start_taken:
        assert property (start_ok && key == KEY_ARMED |=> stall)
        else $error("valid start refused");
    a_start_held:
        assert property (stall |-> nvm_control[CTL_START])
        else $error("start bit low during long write");
    a_start_clear:
        assert property ($fell(stall) |-> !nvm_control[CTL_START])
        else $error("start bit not cleared at end");
    a_erase_kind:
        assert property ($rose(stall) |->
            nvm_control[CTL_ERASE] == $past(op_data[CTL_ERASE]))
        else $error("erase select not followed");
    a_ptr_step:
        assert property (take && op_code == OP_TBL_READ
            && op_mode == PTR_POST_INC |=> table_pointer ==
            {$past(table_pointer[21]), $past(table_pointer[20:0]) + 21'h1})
        else $error("post increment wrong");
    a_ptr_upper:
        assert property (take && (op_code == OP_TBL_READ
            || op_code == OP_TBL_WRITE) |=> $stable(table_pointer[21]))
        else $error("pointer bit 21 changed");
    a_latch_load:
        assert property (take && op_code == OP_TBL_WRITE
            |=> table_byte_latch == $past(op_data))
        else $error("table write latch wrong");

    cover property ($rose(stall) && nvm_control[CTL_ERASE]);
    cover property ($rose(stall) && !nvm_control[CTL_ERASE]);
    cover property (take && op_code == OP_TBL_WRITE);
endmodule

// File: dv/self_program_flash_erase_write_bench.sv
/*
 Self-checking bench: Avalon master drives the core port, flash contents
 observed on the fetch port. Assumes short long-write count in simulation.
*/
module self_program_flash_erase_write_bench import fsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW   = 8;
    localparam int WCYC = 20;
    logic          core_clk = 1'b0;
    logic          resetn;
    logic [2:0]    avs_address;
    logic          avs_read;
    logic          avs_write;
    logic [31:0]   avs_writedata;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    logic          global_interrupt_allow;
    logic [AW-1:0] fetch_addr;
    logic [7:0]    fetch_data;
    logic [7:0]    lfsr = 8'h60;
    logic [7:0]    blk [8];
    logic [31:0]   rd;
    int            n_errors = 0;
    int            n_checks = 0;

    fsp_link_if link_inst ();
    fsp_flash_ctrl #(.FLASH_AW(AW), .WRITE_CYCLES_P(WCYC)) fsp_flash_ctrl_inst
    (
        .core_clk(core_clk), .resetn(resetn), .ce(1'b1),
        .link(link_inst.dev), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data)
    );
    fsp_core_port fsp_core_port_inst
    (
        .core_clk(core_clk), .resetn(resetn), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .global_interrupt_allow(global_interrupt_allow),
        .link(link_inst.core)
    );
    fsp_asserts #(.WRITE_CYCLES_P(WCYC)) fsp_asserts_inst
    (
        .core_clk(core_clk), .resetn(resetn),
        .op_valid(link_inst.op_valid), .op_code(link_inst.op_code),
        .op_mode(link_inst.op_mode), .op_data(link_inst.op_data),
        .stall(link_inst.stall), .table_pointer(link_inst.table_pointer),
        .table_byte_latch(link_inst.table_byte_latch),
        .nvm_control(link_inst.nvm_control)
    );

    always #10 core_clk = ~core_clk;

    function automatic logic [7:0] next_rand();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    function automatic logic [7:0] ctl(input logic er, input logic wa);
        logic [7:0] c;
        c = 8'h00;
        c[CTL_PGM_SEL] = 1'b1;
        c[CTL_ERASE] = er;
        c[CTL_WALLOW] = wa;
        c[CTL_START] = 1'b1;
        return c;
    endfunction

    function automatic logic [21:0] ptr_inc(input logic [21:0] p);
        return {p[21], p[20:0] + 21'h1};
    endfunction

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic av(input logic w, input logic [2:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic chk_flash(input logic [AW-1:0] a, input logic [7:0] e);
        fetch_addr <= a;
        repeat (2) @(posedge core_clk);
        chk({24'h00_0000, fetch_data}, {24'h00_0000, e});
    endtask

    task automatic cmd(input fsp_op_type op, input fsp_ptr_mode_type m,
                       input logic [7:0] d);
        av(1'b1, REG_COMMAND, {16'h0000, d, 2'b00, m, 1'b0, op}, rd);
    endtask

    task automatic set_ptr(input logic [21:0] p);
        av(1'b1, REG_POINTER, {10'h000, p}, rd);
        cmd(OP_SET_PTR, PTR_KEEP, 8'h00);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 100; k++)
        begin
            av(1'b0, REG_STATUS, 32'h0000_0000, rd);
            if (rd[STAT_BUSY] === 1'b0)
                return;
        end
        n_errors++;
        $display("unexpected at %0t: long write never ended", $time);
    endtask

    task automatic tbl_rd(input fsp_ptr_mode_type m, input logic [7:0] e);
        cmd(OP_TBL_READ, m, 8'h00);
        av(1'b0, REG_STATUS, 32'h0000_0000, rd);
        chk({24'h00_0000, rd[STAT_LATCH_LSB +: 8]}, {24'h00_0000, e});
    endtask

    task automatic launch(input logic [21:0] p, input logic er,
                          input logic wa);
        set_ptr(p);
        cmd(OP_UNLOCK, PTR_KEEP, KEY_FIRST);
        cmd(OP_UNLOCK, PTR_KEEP, KEY_SECOND);
        chk({31'h0, global_interrupt_allow}, 32'h0000_0000);
        cmd(OP_CONTROL, PTR_KEEP, ctl(er, wa));
        wait_idle();
        repeat (3) @(posedge core_clk);
        chk({31'h0, global_interrupt_allow}, {31'h0, wa});
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end

    initial
    begin
        logic [7:0] r;
        resetn = 1'b0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        fetch_addr = '0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        av(1'b0, REG_CONTROL, 32'h0000_0000, rd);
        chk(rd, {24'h00_0000, CTL_RESET});
        av(1'b0, 3'h7, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        av(1'b1, REG_INT, 32'h0000_0001, rd);
        av(1'b0, REG_INT, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0001);
        for (int i = 1; i < 3; i++)
        begin
            r = next_rand();
            launch({14'h0000, 2'(i), r[5:0]}, 1'b1, 1'b1);
        end
        for (int i = 64; i < 192; i++)
            chk_flash(AW'(i), ERASED_BYTE);
        set_ptr(22'h00_0040);
        for (int i = 0; i < 8; i++)
        begin
            blk[i] = next_rand();
            cmd(OP_TBL_WRITE, PTR_POST_INC, blk[i]);
        end
        av(1'b0, REG_POINTER, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0048);
        launch(22'h00_0040, 1'b0, 1'b0);
        chk_flash(8'h40, ERASED_BYTE);
        // Broken key: 55h, stray byte, AAh
        set_ptr(22'h00_0040);
        cmd(OP_UNLOCK, PTR_KEEP, KEY_FIRST);
        cmd(OP_UNLOCK, PTR_KEEP, 8'h33);
        cmd(OP_UNLOCK, PTR_KEEP, KEY_SECOND);
        cmd(OP_CONTROL, PTR_KEEP, ctl(1'b0, 1'b1));
        wait_idle();
        chk_flash(8'h41, ERASED_BYTE);
        launch(22'h00_0040, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
            chk_flash(AW'(64 + i), blk[i]);
        chk_flash(8'h48, ERASED_BYTE);
        launch(22'h00_0083, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
            chk_flash(AW'(128 + i), blk[i]);
        set_ptr(22'h00_0080);
        for (int i = 0; i < 8; i++)
        begin
            cmd(OP_TBL_READ, PTR_POST_INC, 8'h00);
            av(1'b0, REG_STATUS, 32'h0000_0000, rd);
            chk({24'h00_0000, rd[STAT_LATCH_LSB +: 8]},
                {24'h00_0000, blk[i]});
        end
        set_ptr(22'h00_0082);
        tbl_rd(PTR_PRE_INC, blk[3]);
        tbl_rd(PTR_POST_DEC, blk[3]);
        tbl_rd(PTR_KEEP, blk[2]);
        av(1'b0, REG_POINTER, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0082);
        r = next_rand();
        launch({16'h0001, r[5:0]}, 1'b1, 1'b1);
        for (int i = 64; i < 128; i++)
            chk_flash(AW'(i), ERASED_BYTE);
        chk_flash(8'h80, blk[0]);
        set_ptr(22'h3F_FFFF);
        cmd(OP_TBL_READ, PTR_POST_INC, 8'h00);
        av(1'b0, REG_POINTER, 32'h0000_0000, rd);
        chk(rd, {10'h000, ptr_inc(22'h3F_FFFF)});
        final_report();
    end
endmodule
